/* File: hdl/hps_params.svh */
`ifndef HPS_PARAMS_SVH
`define HPS_PARAMS_SVH
// Notes on behaviour
// - Select pin high means SPI, low I2C
// - Shared data pin: SPI output or open-drain SDA
// - SPI answers only while chip select low
// - SPI data input sampled from second address pin
// - I2C address pins give two address bits
// - Interrupt pin pulled low while interrupt pending
// - Reset pin low holds hardware reset
// - Oscillator and PLL stopped during reset
// - Four GPIOs: input, push-pull or open-drain
// - RTS output follows line control bit 7
// - CTS input sampled for flow control
`define HPS_BYTE_W 8
`define HPS_GPIO_N 4
`define HPS_RTS_BIT 3'h7
`define HPS_BIT_LAST 3'h7
`define HPS_SPI_MAX_HZ 26000000
`define HPS_I2C_MAX_HZ 400000
`define HPS_CORE_HZ 20000000
`define HPS_WAKE_CYCLES 4'h4
`define HPS_LCR_RESET 8'h05
`endif

/* File: hdl/hps_pkg.sv */
package hps_pkg;
   typedef logic [7:0] hps_byte_t;
   typedef logic [3:0] hps_gpio_t;
   typedef enum logic {
      HPS_HOST_I2C = 1'b0,
      HPS_HOST_SPI = 1'b1
   } hps_host_t;
   typedef enum logic [1:0] {
      HPS_PWR_RESET = 2'b00,
      HPS_PWR_WAKE = 2'b01,
      HPS_PWR_RUN = 2'b10
   } hps_pwr_t;
endpackage

/* File: hdl/hps_spi_shifter.sv */
`include "hps_params.svh"
module hps_spi_shifter (
   // Link clock, frame reset and power-on reset
   input wire logic spi_clk_i,
   input wire logic spi_rst_n_i,
   input wire logic arst_n_i,
   // Serial pins
   input wire logic mosi_i,
   output logic miso_o,
   // Byte side
   input wire hps_pkg::hps_byte_t tx_byte_i,
   output hps_pkg::hps_byte_t rx_byte_o,
   output logic rx_toggle_o
);
   import hps_pkg::*;

   logic [2:0] bit_cnt;
   hps_byte_t rx_shift;
   hps_byte_t tx_shift;

   always_ff @(posedge spi_clk_i or negedge spi_rst_n_i) begin
      if (!spi_rst_n_i) begin
         bit_cnt <= 3'h0;
      end else begin
         bit_cnt <= bit_cnt + 3'h1;
      end
   end

   // MSB first, sampled on the rising edge
   always_ff @(posedge spi_clk_i or negedge spi_rst_n_i) begin
      if (!spi_rst_n_i) begin
         rx_shift <= 8'h00;
      end else begin
         rx_shift <= {rx_shift[6:0], mosi_i};
      end
   end

   // Event toggle keeps its level when chip select rises, or a frame end looks like a byte
   always_ff @(posedge spi_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_byte_o <= 8'h00;
         rx_toggle_o <= 1'b0;
      end else if (bit_cnt == `HPS_BIT_LAST) begin
         rx_byte_o <= {rx_shift[6:0], mosi_i};
         rx_toggle_o <= ~rx_toggle_o;
      end
   end

   always_ff @(posedge spi_clk_i or negedge spi_rst_n_i) begin
      if (!spi_rst_n_i) begin
         tx_shift <= 8'h00;
      end else if (bit_cnt == 3'h0) begin
         tx_shift <= {tx_byte_i[6:0], 1'b0};
      end else begin
         tx_shift <= {tx_shift[6:0], 1'b0};
      end
   end

   // First bit is valid as soon as the frame opens
   assign miso_o = (bit_cnt == 3'h0) ? tx_byte_i[7] : tx_shift[7];

   spi_byte_wrap_a: assert property (@(posedge spi_clk_i) disable iff (!spi_rst_n_i)
      (bit_cnt == `HPS_BIT_LAST) |=> (rx_toggle_o != $past(rx_toggle_o)))
      else $error("received byte not flagged after eighth bit");
endmodule

/* File: hdl/hps_pin_mux.sv */
`include "hps_params.svh"
module hps_pin_mux (
   // Core clock and reset pin
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // Host port selection pin
   input wire logic host_select_i,
   // Shared host pins
   input wire logic sclk_scl_i,
   input wire logic select_or_addr0_i,
   input wire logic serial_in_or_addr1_i,
   input wire logic dout_sda_i,
   output logic dout_sda_o,
   output logic dout_sda_oe_n_o,
   // Interrupt pin
   output logic irq_o,
   output logic irq_oe_n_o,
   // General-purpose pins
   input wire hps_pkg::hps_gpio_t general_pin_i,
   output hps_pkg::hps_gpio_t general_pin_o,
   output hps_pkg::hps_gpio_t general_pin_oe_n_o,
   // Flow-control pins
   output logic request_to_send_out_o,
   input wire logic clear_to_send_n_i,
   // Core: interrupt and line control
   input wire logic irq_pending_i,
   input wire hps_pkg::hps_byte_t line_control_i,
   // Core: GPIO configuration and data
   input wire hps_pkg::hps_gpio_t gpio_dir_out_i,
   input wire hps_pkg::hps_gpio_t gpio_open_drain_i,
   input wire hps_pkg::hps_gpio_t gpio_out_data_i,
   output hps_pkg::hps_gpio_t gpio_in_data_o,
   // Core: flow-control status
   output logic cts_active_o,
   // Core: host mode and power status
   output hps_pkg::hps_host_t host_mode_o,
   output logic osc_enable_o,
   output logic clock_ready_o,
   // Core: SPI byte path
   input wire hps_pkg::hps_byte_t spi_tx_byte_i,
   output hps_pkg::hps_byte_t spi_rx_byte_o,
   output logic spi_rx_valid_o,
   output logic spi_active_o,
   // Core: I2C line access
   output logic i2c_scl_o,
   output logic i2c_sda_o,
   input wire logic i2c_sda_pull_low_i,
   output logic [1:0] i2c_addr_bits_o
);
   import hps_pkg::*;

   // Two-flop synchronisers for pin levels
   logic host_sel_s1, host_sel_s2;
   logic cs_s1, cs_s2;
   logic a1_s1, a1_s2;
   logic scl_s1, scl_s2;
   logic sda_s1, sda_s2;
   logic cts_s1, cts_s2;
   hps_gpio_t gpin_s1, gpin_s2;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         host_sel_s1 <= 1'b0;
         host_sel_s2 <= 1'b0;
      end else begin
         host_sel_s1 <= host_select_i;
         host_sel_s2 <= host_sel_s1;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         a1_s1 <= 1'b0;
         a1_s2 <= 1'b0;
      end else begin
         cs_s1 <= select_or_addr0_i;
         cs_s2 <= cs_s1;
         a1_s1 <= serial_in_or_addr1_i;
         a1_s2 <= a1_s1;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
      end else begin
         scl_s1 <= sclk_scl_i;
         scl_s2 <= scl_s1;
         sda_s1 <= dout_sda_i;
         sda_s2 <= sda_s1;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cts_s1 <= 1'b1;
         cts_s2 <= 1'b1;
         gpin_s1 <= 4'h0;
         gpin_s2 <= 4'h0;
      end else begin
         cts_s1 <= clear_to_send_n_i;
         cts_s2 <= cts_s1;
         gpin_s1 <= general_pin_i;
         gpin_s2 <= gpin_s1;
      end
   end

   // Power sequence: reset holds everything, wake latches straps
   hps_pwr_t pwr_state;
   hps_pwr_t next_pwr_state;
   logic [3:0] wake_cnt;

   always_comb begin
      next_pwr_state = pwr_state;
      case (pwr_state)
         HPS_PWR_RESET: next_pwr_state = HPS_PWR_WAKE;
         HPS_PWR_WAKE: begin
            if (wake_cnt == `HPS_WAKE_CYCLES) begin
               next_pwr_state = HPS_PWR_RUN;
            end
         end
         HPS_PWR_RUN: next_pwr_state = HPS_PWR_RUN;
         default: next_pwr_state = HPS_PWR_RESET;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pwr_state <= HPS_PWR_RESET;
      end else begin
         pwr_state <= next_pwr_state;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wake_cnt <= 4'h0;
      end else if (pwr_state == HPS_PWR_WAKE) begin
         wake_cnt <= wake_cnt + 4'h1;
      end
   end

   // Oscillator and PLL enables are off for the whole reset
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         osc_enable_o <= 1'b0;
         clock_ready_o <= 1'b0;
      end else begin
         osc_enable_o <= 1'b1;
         clock_ready_o <= (next_pwr_state == HPS_PWR_RUN);
      end
   end

   // Host mode follows the synchronised select level
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         host_mode_o <= HPS_HOST_I2C;
      end else begin
         host_mode_o <= host_sel_s2 ? HPS_HOST_SPI : HPS_HOST_I2C;
      end
   end

   // Address straps are caught once, at the end of wake
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         i2c_addr_bits_o <= 2'h0;
      end else if (pwr_state == HPS_PWR_WAKE && wake_cnt == `HPS_WAKE_CYCLES) begin
         i2c_addr_bits_o <= {a1_s2, cs_s2};
      end
   end

   // I2C line levels to the core
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         i2c_scl_o <= 1'b1;
         i2c_sda_o <= 1'b1;
      end else begin
         i2c_scl_o <= scl_s2;
         i2c_sda_o <= sda_s2;
      end
   end

   // SPI side: link domain reset while deselected or not in SPI mode
   logic spi_rst_n;
   logic spi_miso;
   hps_byte_t spi_rx_link;
   logic spi_rx_toggle;
   hps_byte_t tx_hold;

   assign spi_rst_n = arst_n_i & host_select_i & ~select_or_addr0_i;

   // Transmit byte is only changed while the frame is closed
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_hold <= 8'h00;
      end else if (cs_s2) begin
         tx_hold <= spi_tx_byte_i;
      end
   end

   hps_spi_shifter u_shifter (
      .spi_clk_i (sclk_scl_i),
      .spi_rst_n_i (spi_rst_n),
      .arst_n_i (arst_n_i),
      .mosi_i (serial_in_or_addr1_i),
      .miso_o (spi_miso),
      .tx_byte_i (tx_hold),
      .rx_byte_o (spi_rx_link),
      .rx_toggle_o (spi_rx_toggle)
   );

   // Toggle crossing for the received-byte event
   logic tog_s1, tog_s2, tog_s3;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tog_s1 <= 1'b0;
         tog_s2 <= 1'b0;
         tog_s3 <= 1'b0;
      end else begin
         tog_s1 <= spi_rx_toggle;
         tog_s2 <= tog_s1;
         tog_s3 <= tog_s2;
      end
   end

   // Byte stays stable for eight link clocks after its toggle
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         spi_rx_byte_o <= 8'h00;
         spi_rx_valid_o <= 1'b0;
      end else begin
         spi_rx_valid_o <= (tog_s2 != tog_s3) && host_sel_s2;
         if (tog_s2 != tog_s3) begin
            spi_rx_byte_o <= spi_rx_link;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         spi_active_o <= 1'b0;
      end else begin
         spi_active_o <= host_sel_s2 & ~cs_s2;
      end
   end

   // Shared data pin: SPI drives while selected, I2C only pulls low
   always_comb begin
      if (host_select_i) begin
         dout_sda_o = spi_miso;
         dout_sda_oe_n_o = select_or_addr0_i;
      end else begin
         dout_sda_o = 1'b0;
         dout_sda_oe_n_o = ~i2c_sda_pull_low_i;
      end
   end

   // Interrupt pin: open drain, active low
   logic irq_drive;
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_drive <= 1'b0;
      end else begin
         irq_drive <= irq_pending_i;
      end
   end

   assign irq_o = 1'b0;
   assign irq_oe_n_o = ~irq_drive;

   // RTS pin follows the line control bit; idle level after reset
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         request_to_send_out_o <= 1'(`HPS_LCR_RESET >> `HPS_RTS_BIT);
      end else begin
         request_to_send_out_o <= line_control_i[`HPS_RTS_BIT];
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cts_active_o <= 1'b0;
      end else begin
         cts_active_o <= ~cts_s2;
      end
   end

   // General-purpose pins, one slice per pin
   hps_gpio_t gpo_val;
   hps_gpio_t gpo_oe_n;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gpio_in_data_o <= 4'h0;
      end else begin
         gpio_in_data_o <= gpin_s2;
      end
   end

   for (genvar g = 0; g < `HPS_GPIO_N; g++) begin : g_gpio
      always_ff @(posedge core_clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            gpo_val[g] <= 1'b0;
            gpo_oe_n[g] <= 1'b1;
         end else if (!gpio_dir_out_i[g]) begin
            gpo_val[g] <= 1'b0;
            gpo_oe_n[g] <= 1'b1;
         end else if (gpio_open_drain_i[g]) begin
            gpo_val[g] <= 1'b0;
            gpo_oe_n[g] <= gpio_out_data_i[g];
         end else begin
            gpo_val[g] <= gpio_out_data_i[g];
            gpo_oe_n[g] <= 1'b0;
         end
      end
   end

   assign general_pin_o = gpo_val;
   assign general_pin_oe_n_o = gpo_oe_n;

   irq_follows_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      irq_pending_i |=> (!irq_oe_n_o && !irq_o))
      else $error("interrupt pin not pulled low while pending");

   irq_release_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      !irq_pending_i |=> irq_oe_n_o)
      else $error("interrupt pin held low with nothing pending");

   rts_follow_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      ##1 request_to_send_out_o == $past(line_control_i[7]))
      else $error("RTS pin does not follow line control bit");

   cts_latency_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      $fell(clear_to_send_n_i) ##1 !clear_to_send_n_i[*2] |=> cts_active_o)
      else $error("CTS not seen three cycles after falling");

   osc_start_a: assert property (@(posedge core_clk_i)
      !arst_n_i |-> (!osc_enable_o && !clock_ready_o))
      else $error("clock enabled during reset");

   clk_ready_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      $rose(osc_enable_o) |-> ##[5:7] clock_ready_o)
      else $error("clock ready not reached after wake");

   host_mode_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      host_select_i [*4] |-> host_mode_o == HPS_HOST_SPI)
      else $error("host mode not SPI with select high");

   sda_i2c_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (!host_select_i && !i2c_sda_pull_low_i) |-> dout_sda_oe_n_o)
      else $error("SDA driven in I2C mode without request");

   spi_deselect_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (host_select_i && select_or_addr0_i) |-> dout_sda_oe_n_o)
      else $error("data pin driven while chip select high");

   gpio_input_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      !gpio_dir_out_i[0] |=> general_pin_oe_n_o[0])
      else $error("GPIO driven while configured as input");

   strap_hold_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (pwr_state == HPS_PWR_RUN) |=> $stable(i2c_addr_bits_o))
      else $error("address bits changed after wake");
endmodule

/* File: test/hps_spi_host.sv */
// Host controller model on the SPI side of the shared pins (mode 0, MSB first)
module hps_spi_host (
   // Link reference clock
   input wire logic link_clk_i,
   // Serial pins
   input wire logic miso_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import hps_pkg::*;

   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge link_clk_i);
   endtask

   // Clock idles low between frames; four reference ticks per phase keeps SCLK slow
   task automatic frame(input logic sel, input int nb, input logic [15:0] tx,
                        output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge link_clk_i);
      cs_n_o <= ~sel;
      for (int i = 0; i < 8 * nb; i++) begin
         mosi_o <= tx[15 - i];
         tick(4);
         rx = {rx[14:0], miso_i};
         sclk_o <= 1'b1;
         tick(4);
         sclk_o <= 1'b0;
      end
      tick(4);
      cs_n_o <= 1'b1;
      // Released data line no longer holds the last bit
      mosi_o <= ~mosi_o;
      tick(4);
   endtask
endmodule

/* File: test/hps_pin_mux_tb.sv */
module hps_pin_mux_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import hps_pkg::*;

   typedef struct packed {
      logic irq;
      hps_byte_t line_control_register;
      hps_gpio_t dir, od, dat, pin;
      logic cts_n, e_irq_oe_n, e_rts;
      hps_gpio_t e_oe_n, e_out;
   } hps_row_t;

   // Reset pin idles high so that its first fall is a real edge
   logic core_clk_i = 1'b0, link_clk = 1'b0, arst_n_i = 1'b1, host_select_i = 1'b1;
   logic scl = 1'b1, strap0 = 1'b0, strap1 = 1'b0, sda_host_low = 1'b0;
   logic sclk, cs_n, mosi, dout_w, dout_sda_o, dout_sda_oe_n_o;
   logic irq_pending_i = 1'b0, clear_to_send_n_i = 1'b1, i2c_sda_pull_low_i = 1'b0;
   hps_byte_t line_control_i = 8'h00, spi_tx_byte_i = 8'h00, spi_rx_byte_o;
   hps_gpio_t general_pin_i = 4'h0, gpio_dir_out_i = 4'h0, gpio_open_drain_i = 4'h0;
   hps_gpio_t gpio_out_data_i = 4'h0, general_pin_o, general_pin_oe_n_o, gpio_in_data_o;
   logic irq_o, irq_oe_n_o, request_to_send_out_o, cts_active_o, osc_enable_o;
   logic clock_ready_o, spi_rx_valid_o, spi_active_o, i2c_scl_o, i2c_sda_o;
   logic [1:0] i2c_addr_bits_o;
   hps_host_t host_mode_o;
   hps_byte_t rxq[$];
   hps_row_t rows[4];
   logic [15:0] rx;
   int n_fail = 0, num_checks = 0, n_drv = 0, n_act = 0, q0, d0, a0;

   always #25 core_clk_i = ~core_clk_i;
   always #6 link_clk = ~link_clk;

   // Undriven SPI line shows the inverse of its last value; SDA has a pull-up
   assign dout_w = host_select_i ? (dout_sda_oe_n_o ? ~dout_sda_o : dout_sda_o)
                                 : ~((~dout_sda_oe_n_o & ~dout_sda_o) | sda_host_low);

   hps_spi_host u_host (.link_clk_i(link_clk), .miso_i(dout_w), .sclk_o(sclk),
                        .cs_n_o(cs_n), .mosi_o(mosi));

   hps_pin_mux u_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
      .host_select_i(host_select_i), .sclk_scl_i(host_select_i ? sclk : scl),
      .select_or_addr0_i(host_select_i ? cs_n : strap0),
      .serial_in_or_addr1_i(host_select_i ? mosi : strap1), .dout_sda_i(dout_w),
      .dout_sda_o(dout_sda_o), .dout_sda_oe_n_o(dout_sda_oe_n_o), .irq_o(irq_o),
      .irq_oe_n_o(irq_oe_n_o), .general_pin_i(general_pin_i), .general_pin_o(general_pin_o),
      .general_pin_oe_n_o(general_pin_oe_n_o), .request_to_send_out_o(request_to_send_out_o),
      .clear_to_send_n_i(clear_to_send_n_i), .irq_pending_i(irq_pending_i),
      .line_control_i(line_control_i), .gpio_dir_out_i(gpio_dir_out_i),
      .gpio_open_drain_i(gpio_open_drain_i), .gpio_out_data_i(gpio_out_data_i),
      .gpio_in_data_o(gpio_in_data_o), .cts_active_o(cts_active_o),
      .host_mode_o(host_mode_o), .osc_enable_o(osc_enable_o), .clock_ready_o(clock_ready_o),
      .spi_tx_byte_i(spi_tx_byte_i), .spi_rx_byte_o(spi_rx_byte_o),
      .spi_rx_valid_o(spi_rx_valid_o), .spi_active_o(spi_active_o), .i2c_scl_o(i2c_scl_o),
      .i2c_sda_o(i2c_sda_o), .i2c_sda_pull_low_i(i2c_sda_pull_low_i),
      .i2c_addr_bits_o(i2c_addr_bits_o));

   always @(negedge core_clk_i) begin
      if (spi_rx_valid_o === 1'b1) begin
         rxq.push_back(spi_rx_byte_o);
      end
      if (dout_sda_oe_n_o === 1'b0) begin
         n_drv++;
      end
      if (spi_active_o === 1'b1) begin
         n_act++;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Mode changes only while the part is held in reset
   task automatic do_reset(input logic sel);
      int k;
      @(negedge core_clk_i);
      arst_n_i = 1'b0;
      host_select_i = sel;
      cyc(10);
      chk({osc_enable_o, clock_ready_o}, 16'h0000);
      chk({irq_oe_n_o, general_pin_oe_n_o, request_to_send_out_o}, 16'h003e);
      arst_n_i = 1'b1;
      cyc(1);
      chk(osc_enable_o, 16'h0001);
      k = 0;
      while (clock_ready_o !== 1'b1 && k < 20) begin
         cyc(1);
         k++;
      end
      chk(clock_ready_o, 16'h0001);
   endtask

   initial begin
      #400000;
      n_fail++;
      end_of_test();
   end

   initial begin
      rows[0] = {1'b1, 8'h80, 4'hf, 4'h0, 4'ha, 4'h5, 1'b0, 1'b0, 1'b1, 4'h0, 4'ha};
      rows[1] = {1'b0, 8'h7f, 4'h0, 4'hf, 4'hf, 4'ha, 1'b1, 1'b1, 1'b0, 4'hf, 4'h0};
      rows[2] = {1'b1, 8'hff, 4'hf, 4'hf, 4'h6, 4'h3, 1'b0, 1'b0, 1'b1, 4'h6, 4'h0};
      rows[3] = {1'b0, 8'h05, 4'h5, 4'h1, 4'h3, 4'hc, 1'b1, 1'b1, 1'b0, 4'hb, 4'h0};
      do_reset(1'b1);
      chk(host_mode_o, HPS_HOST_SPI);
      foreach (rows[i]) begin
         irq_pending_i = rows[i].irq;
         line_control_i = rows[i].line_control_register;
         gpio_dir_out_i = rows[i].dir;
         gpio_open_drain_i = rows[i].od;
         gpio_out_data_i = rows[i].dat;
         general_pin_i = rows[i].pin;
         clear_to_send_n_i = rows[i].cts_n;
         cyc(1);
         chk({irq_oe_n_o, request_to_send_out_o}, {rows[i].e_irq_oe_n, rows[i].e_rts});
         chk({general_pin_oe_n_o, general_pin_o & rows[i].dir},
             {rows[i].e_oe_n, rows[i].e_out});
         cyc(3);
         chk(gpio_in_data_o, rows[i].pin);
         chk(cts_active_o, !rows[i].cts_n);
      end
      // Two bytes back to back in one frame; the same reply byte repeats
      spi_tx_byte_i = 8'h96;
      cyc(3);
      q0 = rxq.size();
      a0 = n_act;
      u_host.frame(1'b1, 2, 16'ha53c, rx);
      cyc(6);
      chk(rx, 16'h9696);
      chk(n_act > a0, 16'h0001);
      chk(rxq.size() - q0, 16'h0002);
      if (rxq.size() == q0 + 2) begin
         chk({rxq[q0], rxq[q0 + 1]}, 16'ha53c);
      end
      // A one-byte frame gives exactly one byte, also after chip select rises
      q0 = rxq.size();
      u_host.frame(1'b1, 1, 16'hc300, rx);
      cyc(6);
      chk(rx, 16'h0096);
      chk(rxq.size() - q0, 16'h0001);
      if (rxq.size() > q0) begin
         chk(rxq[q0], 16'h00c3);
      end
      // Clock pulses without chip select are ignored and the data pin stays released
      q0 = rxq.size();
      d0 = n_drv;
      u_host.frame(1'b0, 1, 16'h5a00, rx);
      cyc(6);
      chk(rxq.size() - q0, 16'h0000);
      chk(n_drv - d0, 16'h0000);
      chk(spi_active_o, 16'h0000);
      strap0 = 1'b0;
      strap1 = 1'b1;
      do_reset(1'b0);
      chk(host_mode_o, HPS_HOST_I2C);
      chk(i2c_addr_bits_o, 16'h0002);
      scl = 1'b0;
      i2c_sda_pull_low_i = 1'b1;
      cyc(4);
      chk(i2c_scl_o, 16'h0000);
      chk({dout_sda_oe_n_o, dout_sda_o, i2c_sda_o}, 16'h0000);
      i2c_sda_pull_low_i = 1'b0;
      cyc(4);
      chk({dout_sda_oe_n_o, i2c_sda_o}, 16'h0003);
      sda_host_low = 1'b1;
      scl = 1'b1;
      cyc(4);
      chk({i2c_scl_o, i2c_sda_o}, 16'h0002);
      end_of_test();
   end
endmodule
